// ---- fso_btn_decode.sv ----
// Pushbutton pattern decoder and stuck-button detector.
// Assumes a synchronised, active-high pressed level on this clock.
`timescale 1ns/1ps
`default_nettype none
`include "fso_map.svh"

module fso_btn_decode
  import fso_pkg::*;
#(
  parameter int unsigned HALF_CYC  = 20,
  parameter int unsigned STUCK_CYC = 400
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic pressed_i,
  output logic      action_o,
  output logic      stuck_o
);

  // Accepted phase length is half a second within a quarter
  localparam int unsigned LO_CYC = HALF_CYC - HALF_CYC / `FSO_TOL_DIV;
  localparam int unsigned HI_CYC = HALF_CYC + HALF_CYC / `FSO_TOL_DIV;

  if (HALF_CYC < 8 || STUCK_CYC <= HI_CYC * 3) begin : g_chk
    $error("fso_btn_decode: timing parameters out of range");
  end

  fso_btn_t q;
  fso_btn_t n;
  logic     in_win;

  // Phase length at its exit cycle is cnt + 1
  assign in_win = (q.cnt + 32'h0000_0001 >= LO_CYC) &&
                  (q.cnt + 32'h0000_0001 <= HI_CYC);

  // Pattern walker; any deviation drops back without an action
  always_comb begin
    n        = q;
    n.action = 1'b0;
    n.cnt    = q.cnt + 32'h0000_0001;
    unique case (q.st)
      FSO_BTN_IDLE: begin
        n.cnt = '0;
        if (pressed_i) begin
          n.st = FSO_BTN_PRESS1;
        end
      end
      FSO_BTN_PRESS1: begin
        if (!pressed_i) begin
          n.st  = in_win ? FSO_BTN_GAP : FSO_BTN_IDLE;
          n.cnt = '0;
        end else if (q.cnt >= HI_CYC) begin
          n.st = FSO_BTN_WAITUP;
        end
      end
      FSO_BTN_GAP: begin
        if (pressed_i) begin
          n.st  = in_win ? FSO_BTN_PRESS2 : FSO_BTN_WAITUP;
          n.cnt = '0;
        end else if (q.cnt >= HI_CYC) begin
          n.st = FSO_BTN_IDLE;
        end
      end
      FSO_BTN_PRESS2: begin
        if (!pressed_i) begin
          n.st     = FSO_BTN_IDLE;
          n.action = in_win;
        end else if (q.cnt >= HI_CYC) begin
          n.st = FSO_BTN_WAITUP;
        end
      end
      FSO_BTN_WAITUP: begin
        // A long hold must end before a new pattern can start
        n.cnt = '0;
        if (!pressed_i) begin
          n.st = FSO_BTN_IDLE;
        end
      end
      default: begin
        n.st = FSO_BTN_IDLE;
      end
    endcase
    // Stuck detection runs beside the walker
    if (!pressed_i) begin
      n.hold = '0;
    end else if (q.hold < STUCK_CYC) begin
      n.hold = q.hold + 32'h0000_0001;
    end
    n.stuck = pressed_i && (q.hold >= STUCK_CYC);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: FSO_BTN_IDLE, cnt: '0, hold: '0,
             action: 1'b0, stuck: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign action_o = q.action;
  assign stuck_o  = q.stuck;

endmodule
`default_nettype wire

// ---- fso_btn_operator.sv ----
// Field operator model working the zero and span pushbuttons.
// Assumes go_i is a one-cycle pulse and len_i counts clock cycles.
`timescale 1ns/1ps
`default_nettype none

module fso_btn_operator (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        span_i,
  input  wire logic [15:0] len_i,
  output logic             zero_btn_o = 1'b0,
  output logic             span_btn_o = 1'b0,
  output logic             busy_o     = 1'b0
);
  // Press, release, press, release; off-length phases on request
  always @(posedge clk_i) begin
    if (go_i) begin
      busy_o <= 1'b1;
      repeat (2) begin
        zero_btn_o <= !span_i;
        span_btn_o <= span_i;
        repeat (len_i) @(posedge clk_i);
        zero_btn_o <= 1'b0;
        span_btn_o <= 1'b0;
        repeat (len_i) @(posedge clk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- fso_failsafe_ctrl.sv ----
// Fail-safe output and range control of a loop-powered transmitter.
// Assumes diagnostic inputs on this clock and raw pushbutton pins;
// registers sit on a plain strobe port with read data one cycle late.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fso_map.svh"

module fso_failsafe_ctrl
  import fso_pkg::*;
#(
  parameter int unsigned HALF_CYC  = `FSO_HALF_SEC_MS * `FSO_CLK_KHZ,
  parameter int unsigned STUCK_CYC = `FSO_STUCK_MS * `FSO_CLK_KHZ,
  parameter int unsigned COLD_CYC  = `FSO_COLD_MS * `FSO_CLK_KHZ
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic [15:0] raw_press_i,
  input  wire logic        zero_btn_i,
  input  wire logic        span_btn_i,
  input  wire logic        nvm_fail_i,
  input  wire logic        bridge_open_i,
  input  wire logic        press_hi_i,
  input  wire logic        press_lo_i,
  input  wire logic        temp_hi_i,
  input  wire logic        temp_lo_i,
  input  wire logic        watchdog_i,
  input  wire logic        low_volt_i,
  input  wire logic        rcal_on_i,
  output logic      [15:0] loop_ua_o,
  output logic             alarm_o
);

  if (COLD_CYC < 1 || HALF_CYC < 8) begin : g_chk
    $error("fso_failsafe_ctrl: timing parameters out of range");
  end

  // Reset release through two flip-flops
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  fso_core_t q;
  fso_core_t n;

  logic zero_act;
  logic span_act;
  logic zero_stuck;
  logic span_stuck;

  // One decoder per pushbutton, fed from the second sync stage
  fso_btn_decode #(
    .HALF_CYC  (HALF_CYC),
    .STUCK_CYC (STUCK_CYC)
  ) u_zero_btn (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .pressed_i (q.zb_s2),
    .action_o  (zero_act),
    .stuck_o   (zero_stuck)
  );

  fso_btn_decode #(
    .HALF_CYC  (HALF_CYC),
    .STUCK_CYC (STUCK_CYC)
  ) u_span_btn (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .pressed_i (q.sb_s2),
    .action_o  (span_act),
    .stuck_o   (span_stuck)
  );

  // Pressure value and span
  logic [15:0] primary_pressure_value;
  logic [15:0] span;
  logic [15:0] span_div;
  logic        out_of_range;

  always_comb begin
    if (raw_press_i >= q.zoff) begin
      primary_pressure_value = raw_press_i - q.zoff;
    end else begin
      primary_pressure_value = '0;
    end
    span     = q.upper_range_point - q.lower_range_point;
    // Guard the divider; the checks test the old points, so zero and span actions in one cycle can leave span zero
    span_div = (span == '0) ? 16'h0001 : span;
    out_of_range = (primary_pressure_value < q.lower_range_point) ||
                   (primary_pressure_value > q.upper_range_point);
  end

  // Proportional current with saturation at both ends
  logic [31:0] num;
  logic [31:0] quo;
  logic [15:0] normal_ua;
  logic        saturated;

  always_comb begin
    saturated = 1'b0;
    if (primary_pressure_value >= q.lower_range_point) begin
      num = 32'(primary_pressure_value - q.lower_range_point) *
            32'(`FSO_UA_SPAN);
      quo = num / 32'(span_div);
      if (quo > 32'(`FSO_UA_SAT_HI - `FSO_UA_4MA)) begin
        normal_ua = `FSO_UA_SAT_HI;
        saturated = 1'b1;
      end else begin
        normal_ua = `FSO_UA_4MA + quo[15:0];
      end
    end else begin
      num = 32'(q.lower_range_point - primary_pressure_value) *
            32'(`FSO_UA_SPAN);
      quo = num / 32'(span_div);
      if (quo > 32'(`FSO_UA_4MA - `FSO_UA_SAT_LO)) begin
        normal_ua = `FSO_UA_SAT_LO;
        saturated = 1'b1;
      end else begin
        normal_ua = `FSO_UA_4MA - quo[15:0];
      end
    end
  end

  // Fault classes: latched memory failure, self-clearing bridge and stuck-button faults
  logic fault_live;
  logic alarm;

  assign fault_live = bridge_open_i | zero_stuck | span_stuck;
  assign alarm      = fault_live | q.latched | nvm_fail_i;

  // Span candidate from the span button
  logic [15:0] new_span;
  logic        span_ok;
  logic        zero_ok;
  logic [31:0] turn_prod;

  always_comb begin
    new_span  = primary_pressure_value - q.lower_range_point;
    turn_prod = 32'(new_span) * 32'(`FSO_TURNDOWN);
    span_ok   = (primary_pressure_value > q.lower_range_point) &&
                (turn_prod >= 32'(`FSO_FULL_SCALE)) &&
                (new_span >= q.min_span);
    // Zero shift must not push the upper point past full scale
    zero_ok   = (32'(primary_pressure_value) + 32'(span)) <=
                32'(`FSO_FULL_SCALE);
  end

  // Status word
  logic [15:0] status;

  always_comb begin
    status = {q.reject, rcal_on_i, out_of_range, low_volt_i,
              watchdog_i, saturated, temp_hi_i | temp_lo_i,
              press_lo_i, press_hi_i, span_stuck, zero_stuck,
              bridge_open_i, nvm_fail_i, q.cold, q.latched,
              alarm | q.cold};
  end

  logic        wr_ctrl;
  logic        wr_cmd;
  logic        rej_set;
  logic [15:0] sel_ua;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == `FSO_ADDR_CTRL);
  assign wr_cmd  = reg_wr_i && (reg_addr_i == `FSO_ADDR_CMD);

  // Next-state logic of the whole block
  always_comb begin
    n       = q;
    rej_set = 1'b0;
    // Pushbutton pins enter through two flip-flops
    n.zb_s1 = zero_btn_i;
    n.zb_s2 = q.zb_s1;
    n.sb_s1 = span_btn_i;
    n.sb_s2 = q.sb_s1;

    // Cold start window
    if (q.cold) begin
      if (q.cold_cnt >= COLD_CYC - 1) begin
        n.cold = 1'b0;
      end else begin
        n.cold_cnt = q.cold_cnt + 32'h0000_0001;
      end
    end

    // Register writes
    if (wr_ctrl) begin
      n.fs_sel    = fso_fs_sel_t'(reg_wdata_i[`FSO_CTRL_FS_LSB +: 2]);
      n.multidrop = reg_wdata_i[`FSO_CTRL_MDROP];
      n.local_dis = reg_wdata_i[`FSO_CTRL_LDIS];
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `FSO_ADDR_LRP: begin
          if (q.upper_range_point > reg_wdata_i &&
              q.upper_range_point - reg_wdata_i >= q.min_span) begin
            n.lower_range_point = reg_wdata_i;
          end else begin
            rej_set = 1'b1;
          end
        end
        `FSO_ADDR_URP: begin
          if (reg_wdata_i > q.lower_range_point &&
              reg_wdata_i - q.lower_range_point >= q.min_span) begin
            n.upper_range_point = reg_wdata_i;
          end else begin
            rej_set = 1'b1;
          end
        end
        `FSO_ADDR_MINSPAN: n.min_span = reg_wdata_i;
        `FSO_ADDR_TRIMREF: n.trim_ref = reg_wdata_i;
        `FSO_ADDR_OUTTRIM: n.out_trim = reg_wdata_i;
        default: begin
        end
      endcase
    end

    // Sensor trims correct the digital value only
    if (wr_cmd && reg_wdata_i[`FSO_CMD_ZERO_TRIM]) begin
      if (q.trim_ref == '0) begin
        n.zoff = raw_press_i;
      end else begin
        rej_set = 1'b1;
      end
    end else if (wr_cmd && reg_wdata_i[`FSO_CMD_LOW_TRIM]) begin
      if (q.trim_ref != '0 && raw_press_i >= q.trim_ref) begin
        n.zoff = raw_press_i - q.trim_ref;
      end else begin
        rej_set = 1'b1;
      end
    end

    // Local buttons act last and win over a bus write
    if (zero_act && !q.local_dis) begin
      if (zero_ok) begin
        n.lower_range_point = primary_pressure_value;
        n.upper_range_point = primary_pressure_value + span;
      end else begin
        rej_set = 1'b1;
      end
    end
    if (span_act && !q.local_dis) begin
      if (span_ok) begin
        n.upper_range_point = primary_pressure_value;
      end else begin
        rej_set = 1'b1;
      end
    end

    // Sticky flags: a new set beats a clear in the same cycle
    n.reject  = rej_set |
                (q.reject & ~(wr_cmd & reg_wdata_i[`FSO_CMD_CLR_REJ]));
    n.latched = nvm_fail_i |
                (q.latched &
                 ~(wr_cmd & reg_wdata_i[`FSO_CMD_CLR_LATCH]));

    // Output level selection
    if (q.multidrop) begin
      sel_ua = `FSO_UA_4MA;
    end else if (q.cold) begin
      sel_ua = `FSO_UA_ALM_LO;
    end else if (alarm) begin
      unique case (q.fs_sel)
        FSO_FS_LOW:    sel_ua = `FSO_UA_ALM_LO;
        FSO_FS_FREEZE: sel_ua = q.last_ua;
        default:       sel_ua = `FSO_UA_ALM_HI;
      endcase
    end else begin
      sel_ua    = normal_ua;
      n.last_ua = normal_ua; // Frozen level is the last healthy one
    end
    n.ao_ua   = sel_ua;
    n.loop_ua = sel_ua + q.out_trim;

    // Read data valid only in the cycle after the strobe
    n.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FSO_ADDR_CTRL:    n.rdata = {12'h000, q.local_dis, q.multidrop,
                                      q.fs_sel};
        `FSO_ADDR_LRP:     n.rdata = q.lower_range_point;
        `FSO_ADDR_URP:     n.rdata = q.upper_range_point;
        `FSO_ADDR_MINSPAN: n.rdata = q.min_span;
        `FSO_ADDR_TRIMREF: n.rdata = q.trim_ref;
        `FSO_ADDR_OUTTRIM: n.rdata = q.out_trim;
        `FSO_ADDR_STATUS:  n.rdata = status;
        `FSO_ADDR_PV:      n.rdata = primary_pressure_value;
        `FSO_ADDR_AO:      n.rdata = q.ao_ua;
        `FSO_ADDR_ZOFF:    n.rdata = q.zoff;
        default:           n.rdata = '0;
      endcase
    end
  end

  // State register; cold start begins at every reset
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{zb_s1: 1'b0, zb_s2: 1'b0, sb_s1: 1'b0, sb_s2: 1'b0,
             fs_sel: FSO_FS_HIGH, multidrop: 1'b0, local_dis: 1'b0,
             lower_range_point: `FSO_LRP_RST,
             upper_range_point: `FSO_URP_RST,
             min_span: `FSO_MINSPAN_RST, trim_ref: 16'h0000,
             out_trim: 16'h0000, zoff: 16'h0000,
             latched: 1'b0, reject: 1'b0, cold: 1'b1,
             cold_cnt: 32'h0000_0000, last_ua: `FSO_UA_4MA,
             ao_ua: `FSO_UA_ALM_LO, loop_ua: `FSO_UA_ALM_LO,
             rdata: 16'h0000};
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign loop_ua_o   = q.loop_ua;
  assign alarm_o     = alarm | q.cold;

endmodule
`default_nettype wire

// ---- fso_failsafe_ctrl_sva.sv ----
// Checker of the fail-safe control block, bound to its top module.
// Sees only top ports; the stuck limit follows STUCK_CYC, the cold check holds a fixed 8 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "fso_map.svh"

module fso_failsafe_ctrl_sva #(
  parameter int unsigned HALF_CYC  = 40,
  parameter int unsigned STUCK_CYC = 400,
  parameter int unsigned COLD_CYC  = 10
) (
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        span_btn_i,
  input wire logic        zero_btn_i,
  input wire logic        nvm_fail_i,
  input wire logic        bridge_open_i,
  input wire logic        press_hi_i,
  input wire logic        press_lo_i,
  input wire logic        temp_hi_i,
  input wire logic        temp_lo_i,
  input wire logic        watchdog_i,
  input wire logic        low_volt_i,
  input wire logic        rcal_on_i,
  input wire logic [15:0] loop_ua_o,
  input wire logic        alarm_o
);
  // Margin covers the pin synchroniser and the flag register
  localparam int unsigned STUCK_LIM = STUCK_CYC + 4;
  logic [31:0]     span_hold_reg;
  wire logic [6:0] flags_w = {press_hi_i, press_lo_i, temp_hi_i,
                              temp_lo_i, watchdog_i, low_volt_i, rcal_on_i};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Span pin hold time, saturating
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      span_hold_reg <= 32'h0000_0000;
    end else if (!span_btn_i) begin
      span_hold_reg <= 32'h0000_0000;
    end else if (span_hold_reg != 32'hffff_ffff) begin
      span_hold_reg <= span_hold_reg + 32'h0000_0001;
    end
  end

  sequence s_cold;
    (loop_ua_o == `FSO_UA_ALM_LO && alarm_o) [*8];
  endsequence
  sequence s_bridge;
    bridge_open_i ##1 bridge_open_i;
  endsequence

  property p_cold;
    $rose(nrst_i) |-> s_cold;
  endproperty
  property p_bridge;
    s_bridge |-> alarm_o;
  endproperty
  property p_nvm;
    nvm_fail_i |-> alarm_o;
  endproperty
  property p_latch;
    $fell(nvm_fail_i) |-> alarm_o;
  endproperty
  property p_stuck;
    span_hold_reg > STUCK_LIM |-> alarm_o;
  endproperty
  property p_flag_only;
    $changed(flags_w) && !$past(alarm_o) && !$past(bridge_open_i) &&
    !bridge_open_i && !nvm_fail_i && !zero_btn_i && !span_btn_i
    |-> !alarm_o;
  endproperty
  property p_rd_idle;
    reg_rdata_o != 16'h0000 |-> $past(reg_rd_i);
  endproperty
  property p_unmapped;
    reg_rd_i && reg_addr_i > 8'h2b |=> reg_rdata_o == 16'h0000;
  endproperty

  a_cold: assert property (p_cold)
    else $error("cold start level not held");
  a_bridge: assert property (p_bridge)
    else $error("open bridge without alarm");
  a_nvm: assert property (p_nvm)
    else $error("memory failure without alarm");
  a_latch: assert property (p_latch)
    else $error("memory fault alarm did not latch");
  a_stuck: assert property (p_stuck)
    else $error("stuck button without alarm");
  a_flag_only: assert property (p_flag_only)
    else $error("flag-only condition raised alarm");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule

bind fso_failsafe_ctrl fso_failsafe_ctrl_sva #(
  .HALF_CYC (HALF_CYC),
  .STUCK_CYC(STUCK_CYC),
  .COLD_CYC (COLD_CYC)
) u_sva (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .span_btn_i(span_btn_i), .zero_btn_i(zero_btn_i),
  .nvm_fail_i(nvm_fail_i), .bridge_open_i(bridge_open_i),
  .press_hi_i(press_hi_i), .press_lo_i(press_lo_i),
  .temp_hi_i(temp_hi_i), .temp_lo_i(temp_lo_i),
  .watchdog_i(watchdog_i), .low_volt_i(low_volt_i),
  .rcal_on_i(rcal_on_i), .loop_ua_o(loop_ua_o), .alarm_o(alarm_o)
);
`default_nettype wire

// ---- fso_failsafe_ctrl_tb.sv ----
// Self-checking bench: register and pushbutton scenarios.
// Assumes the bound checker and the operator model beside the block.
`timescale 1ns/1ps
`default_nettype none
`include "fso_map.svh"

module fso_failsafe_ctrl_tb;
  logic        clk_sys_i     = 1'b0;
  logic        nrst_i        = 1'b0;
  logic [7:0]  reg_addr_i    = 8'h00;
  logic [15:0] reg_wdata_i   = 16'h0000;
  logic        reg_wr_i      = 1'b0;
  logic        reg_rd_i      = 1'b0;
  logic [15:0] raw_press_i   = 16'h8000;
  logic        nvm_fail_i    = 1'b0;
  logic        bridge_open_i = 1'b0;
  logic [6:0]  flags         = 7'h00;
  logic        op_go         = 1'b0;
  logic        op_span       = 1'b0;
  logic [15:0] op_len        = 16'h0028;
  logic [15:0] reg_rdata_o;
  logic [15:0] loop_ua_o;
  logic        alarm_o;
  logic        zero_btn_i;
  logic        span_btn_i;
  logic        op_busy;
  logic [15:0] v;
  int          mismatches    = 0;
  int          total_checks  = 0;
  logic [7:0]  ra [8] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                          8'h28, 8'h30};
  logic [15:0] rv [8] = '{16'h0000, `FSO_LRP_RST, `FSO_URP_RST,
                          `FSO_MINSPAN_RST, 16'h0000, 16'h0000,
                          16'h0000, 16'h0000};
  logic [15:0] pr [3] = '{16'h0000, 16'hffff, 16'h8000};
  logic [15:0] pr_ua [3] = '{16'h0fa0, 16'h4e20, 16'h2ee0};
  logic [15:0] fs_ua [3] = '{16'h53fc, 16'h0e10, 16'h2ee0};

  fso_failsafe_ctrl #(.HALF_CYC(40), .STUCK_CYC(400), .COLD_CYC(10)) DUT (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .raw_press_i(raw_press_i),
    .zero_btn_i(zero_btn_i), .span_btn_i(span_btn_i),
    .nvm_fail_i(nvm_fail_i), .bridge_open_i(bridge_open_i),
    .press_hi_i(flags[0]), .press_lo_i(flags[1]), .temp_hi_i(flags[2]),
    .temp_lo_i(flags[3]), .watchdog_i(flags[4]), .low_volt_i(flags[5]),
    .rcal_on_i(flags[6]), .loop_ua_o(loop_ua_o), .alarm_o(alarm_o)
  );

  fso_btn_operator u_operator (
    .clk_i(clk_sys_i), .go_i(op_go), .span_i(op_span), .len_i(op_len),
    .zero_btn_o(zero_btn_i), .span_btn_o(span_btn_i), .busy_o(op_busy)
  );

  // 40 MHz system clock
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycles start just after an edge; idle edge after each write
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(v, e);
  endtask

  task automatic st(input logic e);
    rd(`FSO_ADDR_STATUS);
    chk({15'h0000, v[15]}, {15'h0000, e});
  endtask

  // Output lags one cycle; four edges leave margin
  task automatic look(input logic [15:0] ua, input logic al);
    repeat (4) @(posedge clk_sys_i);
    #1 chk(loop_ua_o, ua);
    chk({15'h0000, alarm_o}, {15'h0000, al});
    @(posedge clk_sys_i);
  endtask

  task automatic btn(input logic sp, input logic [15:0] len, input logic mid);
    op_span <= sp;
    op_len <= len;
    op_go <= 1'b1;
    @(posedge clk_sys_i);
    op_go <= 1'b0;
    if (mid) begin
      repeat (420) @(posedge clk_sys_i);
      #1 chk({15'h0000, alarm_o}, 16'h0001);
    end
    for (int i = 0; i < 4000 && (op_busy !== 1'b0 || i == 0); i++)
      @(posedge clk_sys_i);
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Run needs about 3000 cycles; ten times that cuts a hang
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(loop_ua_o, `FSO_UA_ALM_LO);
    chk({15'h0000, alarm_o}, 16'h0001);
    repeat (30) @(posedge clk_sys_i);
    wr(8'h30, 16'hffff);
    for (int k = 0; k < 8; k++) begin
      rd_chk(ra[k], rv[k]);
    end
    for (int k = 0; k < 3; k++) begin
      raw_press_i <= pr[k];
      look(pr_ua[k], 1'b0);
    end
    // Each fail-safe selection against an open bridge
    for (int k = 0; k < 3; k++) begin
      wr(`FSO_ADDR_CTRL, 16'(k));
      bridge_open_i <= 1'b1;
      look(fs_ua[k], 1'b1);
      rd_chk(`FSO_ADDR_PV, 16'h8000);
      rd_chk(`FSO_ADDR_AO, fs_ua[k]);
      bridge_open_i <= 1'b0;
      look(16'h2ee0, 1'b0);
    end
    wr(`FSO_ADDR_CTRL, 16'h0004);
    bridge_open_i <= 1'b1;
    look(16'h0fa0, 1'b1);
    bridge_open_i <= 1'b0;
    wr(`FSO_ADDR_CTRL, 16'h0000);
    flags <= 7'h7f;
    look(16'h2ee0, 1'b0);
    flags <= 7'h00;
    wr(`FSO_ADDR_OUTTRIM, 16'h0064);
    look(16'h2f44, 1'b0);
    wr(`FSO_ADDR_OUTTRIM, 16'h0000);
    nvm_fail_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    nvm_fail_i <= 1'b0;
    look(16'h53fc, 1'b1);
    wr(`FSO_ADDR_CMD, 16'h0001);
    look(16'h2ee0, 1'b0);
    // Zero trim, refused and accepted lower trim
    raw_press_i <= 16'h0100;
    wr(`FSO_ADDR_CMD, 16'h0002);
    rd_chk(`FSO_ADDR_PV, 16'h0000);
    wr(`FSO_ADDR_CMD, 16'h0004);
    st(1'b1);
    wr(`FSO_ADDR_TRIMREF, 16'h0040);
    wr(`FSO_ADDR_CMD, 16'h0004);
    rd_chk(`FSO_ADDR_ZOFF, 16'h00c0);
    rd_chk(`FSO_ADDR_PV, 16'h0040);
    raw_press_i <= 16'h0000;
    wr(`FSO_ADDR_TRIMREF, 16'h0000);
    wr(`FSO_ADDR_CMD, 16'h000a);
    st(1'b0);
    wr(`FSO_ADDR_LRP, 16'h1000);
    wr(`FSO_ADDR_URP, 16'h1400);
    rd_chk(`FSO_ADDR_URP, 16'hffff);
    st(1'b1);
    wr(`FSO_ADDR_LRP, 16'h0000);
    wr(`FSO_ADDR_URP, 16'h8000);
    wr(`FSO_ADDR_CMD, 16'h0008);
    // Pushbutton zero, span, turndown refusal, bad timing, stuck
    raw_press_i <= 16'h1000;
    btn(1'b0, 16'h0028, 1'b0);
    rd_chk(`FSO_ADDR_LRP, 16'h1000);
    rd_chk(`FSO_ADDR_URP, 16'h9000);
    look(16'h0fa0, 1'b0);
    raw_press_i <= 16'h4000;
    btn(1'b1, 16'h0028, 1'b0);
    rd_chk(`FSO_ADDR_URP, 16'h4000);
    look(16'h4e20, 1'b0);
    raw_press_i <= 16'h2000;
    btn(1'b1, 16'h0028, 1'b0);
    rd_chk(`FSO_ADDR_URP, 16'h4000);
    st(1'b1);
    wr(`FSO_ADDR_CMD, 16'h0008);
    raw_press_i <= 16'h3000;
    btn(1'b1, 16'h0014, 1'b0);
    rd_chk(`FSO_ADDR_URP, 16'h4000);
    st(1'b0);
    btn(1'b1, 16'h01ae, 1'b1);
    look(16'h394a, 1'b0);
    raw_press_i <= 16'h8000;
    look(16'h5014, 1'b0);
    raw_press_i <= 16'h0000;
    look(16'h0ed8, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire

// ---- fso_map.svh ----
// Constants of the fail-safe output and range control block.
// Assumes a 40 MHz system clock and currents coded in microamps.
//
// Function
// - Normal output 4-20 mA proportional to pressure
// - Fail-safe drives high alarm by default
// - Software selects high, low or frozen fail-safe
// - Low alarm 3.6 mA, low saturation 3.8
// - Pressure value stays computed and readable in alarm
// - Process faults clear alarm when cause disappears
// - Memory fault latches until reset or command; bridge and stuck button clear
// - Reported output value is the alarm level
// - Memory, bridge, stuck button apply fail-safe level
// - Cold start forces low alarm level
// - Limit, saturation, watchdog, voltage, shunt only flagged
// - Multidrop mode never uses alarm current levels
// - Output current trim adjusts delivered levels
// - Zero trim at zero, lower trim above
// - Button pattern: press, release, press, each half second
// - Zero action shifts both range points, keeps span
// - Span action sets upper point to pressure
// - Span outside turndown ratio rejected, point unchanged
// - Range changes below minimum span refused
`ifndef FSO_MAP_SVH
`define FSO_MAP_SVH

// Register offsets
`define FSO_ADDR_CTRL     8'h00
`define FSO_ADDR_CMD      8'h04
`define FSO_ADDR_LRP      8'h08
`define FSO_ADDR_URP      8'h0c
`define FSO_ADDR_MINSPAN  8'h10
`define FSO_ADDR_TRIMREF  8'h14
`define FSO_ADDR_OUTTRIM  8'h18
`define FSO_ADDR_STATUS   8'h1c
`define FSO_ADDR_PV       8'h20
`define FSO_ADDR_AO       8'h24
`define FSO_ADDR_ZOFF     8'h28

// Control fields
`define FSO_CTRL_FS_LSB   0
`define FSO_CTRL_MDROP    2
`define FSO_CTRL_LDIS     3
// Command bits, each a one-shot on write
`define FSO_CMD_CLR_LATCH 0
`define FSO_CMD_ZERO_TRIM 1
`define FSO_CMD_LOW_TRIM  2
`define FSO_CMD_CLR_REJ   3

// Reset values and full scale
`define FSO_LRP_RST       16'h0000
`define FSO_URP_RST       16'hffff
`define FSO_MINSPAN_RST   16'h0800
`define FSO_FULL_SCALE    16'hffff

// Loop current levels in microamps
`define FSO_UA_4MA        16'h0fa0
`define FSO_UA_SPAN       16'h3e80
`define FSO_UA_SAT_HI     16'h5014
`define FSO_UA_ALM_HI     16'h53fc
`define FSO_UA_SAT_LO     16'h0ed8
`define FSO_UA_ALM_LO     16'h0e10

// Timing and turndown ratio
`define FSO_CLK_KHZ       40000
`define FSO_HALF_SEC_MS   500
`define FSO_STUCK_MS      10000
`define FSO_COLD_MS       100
`define FSO_TOL_DIV       4
`define FSO_TURNDOWN      6

`endif

// ---- fso_pkg.sv ----
// Types shared by the fail-safe output and range control block.
// Data paths are 16 bits; counters are 32 bits.
package fso_pkg;

  typedef enum logic [1:0] {
    FSO_FS_HIGH   = 2'h0,
    FSO_FS_LOW    = 2'h1,
    FSO_FS_FREEZE = 2'h2
  } fso_fs_sel_t;

  typedef enum logic [4:0] {
    FSO_BTN_IDLE   = 5'h01,
    FSO_BTN_PRESS1 = 5'h02,
    FSO_BTN_GAP    = 5'h04,
    FSO_BTN_PRESS2 = 5'h08,
    FSO_BTN_WAITUP = 5'h10
  } fso_btn_st_t;

  typedef struct packed {
    fso_btn_st_t st;
    logic [31:0] cnt;
    logic [31:0] hold;
    logic        action;
    logic        stuck;
  } fso_btn_t;

  typedef struct packed {
    logic        zb_s1;
    logic        zb_s2;
    logic        sb_s1;
    logic        sb_s2;
    fso_fs_sel_t fs_sel;
    logic        multidrop;
    logic        local_dis;
    logic [15:0] lower_range_point;
    logic [15:0] upper_range_point;
    logic [15:0] min_span;
    logic [15:0] trim_ref;
    logic [15:0] out_trim;
    logic [15:0] zoff;
    logic        latched;
    logic        reject;
    logic        cold;
    logic [31:0] cold_cnt;
    logic [15:0] last_ua;
    logic [15:0] ao_ua;
    logic [15:0] loop_ua;
    logic [15:0] rdata;
  } fso_core_t;

endpackage
